/* File: include/cmpctl_map.vh */
// register map, field positions, reset values and timing for comparator control
`ifndef CMPCTL_MAP_VH
`define CMPCTL_MAP_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define CMPCTL_ADDR_CTRL 12'h000
`define CMPCTL_ADDR_AUX 12'h004
`define CMPCTL_ADDR_IRQ 12'h008

// ************************************************************
// comparator_control fields
// ************************************************************
`define CMPCTL_MODE_LSB 0
`define CMPCTL_MODE_MSB 2
`define CMPCTL_SWITCH_BIT 3
`define CMPCTL_INVERT_BIT 4
`define CMPCTL_RESULT_BIT 6
`define CMPCTL_CTRL_RESET 8'h00

// ************************************************************
// comparator_aux_control fields
// ************************************************************
`define CMPCTL_SYNC_BIT 0
`define CMPCTL_GATESRC_BIT 1
`define CMPCTL_AUX_RESET 8'h02

// ************************************************************
// irq register fields (flag and enables)
// ************************************************************
`define CMPCTL_FLAG_BIT 0
`define CMPCTL_CHG_EN_BIT 1
`define CMPCTL_PERI_EN_BIT 2
`define CMPCTL_GLOB_EN_BIT 3
`define CMPCTL_IRQ_RESET 8'h00

// ************************************************************
// modes
// ************************************************************
`define CMPCTL_MODE_OFF0 3'b000
`define CMPCTL_MODE_PIN1 3'b001
`define CMPCTL_MODE_PIN3 3'b011
`define CMPCTL_MODE_SW_PIN 3'b101
`define CMPCTL_MODE_SW_INT 3'b110
`define CMPCTL_MODE_OFF7 3'b111

// ************************************************************
// timing: instruction cycle is four system clocks
// ************************************************************
`define CMPCTL_QUARTERS 4
`define CMPCTL_SETTLE_NS 1000
`define CMPCTL_CLK_NS 100
`define CMPCTL_SETTLE_CYC ((`CMPCTL_SETTLE_NS + `CMPCTL_CLK_NS - 1) / `CMPCTL_CLK_NS)

`endif

/* File: core/cmpctl_mismatch.v */
// mismatch detector: reference latch, phase sample latch and compare
`include "cmpctl_map.vh"

module cmpctl_mismatch (
   // clock and reset
   input wire clk_sys,
   input wire rst_b,
   // controls
   input wire q1_tick,
   input wire ref_load,
   input wire result_in,
   // status
   output reg mismatch
);

   reg ref_latch;
   reg sample_latch;

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ref_latch <= 1'b0;
         sample_latch <= 1'b0;
         mismatch <= 1'b0;
      end else begin
         if (ref_load) begin
            ref_latch <= result_in;
         end
         if (q1_tick) begin
            sample_latch <= result_in;
         end
         // a read reloads only the reference latch and clears the mismatch in that cycle
         if (ref_load) begin
            mismatch <= 1'b0;
         end else begin
            mismatch <= sample_latch ^ ref_latch;
         end
      end
   end

endmodule // cmpctl_mismatch

/* File: core/cmpctl_top.v */
// comparator control, change detect, wake and timer gate over apb
//
// Functional notes
// - result high when noninverting input higher; invert when output_invert set
// - adjusted result readable at bit 6 and drives output pin in pin modes
// - modes 101 and 110 keep both inverting candidate pins analog
// - switch select set routes positive pin, cleared routes negative pin
// - reference latch captures result on every control register read
// - sample latch takes result each first quarter; differs means mismatch
// - change flag held set while mismatch persists; read ends mismatch
// - control register write also ends mismatch, as write implies read
// - flag cleared only by writing zero; writing one sets it
// - interrupt needs change, peripheral and global enables; flag sets anyway
// - clearing flag during persisting mismatch has no lasting effect
// - change coinciding with a read may fail to set the flag
// - enabled comparator keeps detecting changes during sleep
// - modes 000 and 111 switch the comparator off
// - change wakes from sleep with change and peripheral enables only
// - after wake resume next instruction; vector only if global enable
// - reset returns control registers to reset values, mode 000
// - gate source cleared lets comparator gate the timer when on
// - with sync, result latched on falling timer clock after prescaler
// - gate source select resets to one, choosing external gate pin
// - result on output pin only in modes 001, 011 and 101
//
// The register addresses and the APB register port are this design's own decisions.
`include "cmpctl_map.vh"

module cmpctl_top (
   // clock and reset
   input wire clk_sys,
   input wire rst_b,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // analog comparator and core
   input wire analog_raw,
   input wire core_sleeping,
   input wire timer_clk_prescaled,
   input wire timer_on,
   input wire timer_gate_enable,
   input wire ext_gate_pin,
   // outputs
   output reg comparator_enable,
   output reg inverting_sel_positive,
   output reg positive_pin_analog,
   output reg negative_pin_analog,
   output reg result_pin_out,
   output reg result_pin_oe,
   output reg irq_request,
   output reg wake_request,
   output reg vector_after_wake,
   output reg timer_count_enable
);

   // ************************************************************
   // registers
   // ************************************************************
   reg [2:0] comparator_mode_field;
   reg input_switch_select;
   reg output_invert;
   reg output_sync_select;
   reg timer_gate_source_select;
   reg comparator_change_flag;
   reg comparator_change_enable;
   reg peripheral_irq_enable;
   reg global_irq_enable;
   reg [1:0] quarter;
   reg timer_clk_d;
   reg sync_result;
   reg comparator_result_bit;

   wire apb_access;
   wire wr_ctrl;
   wire rd_ctrl;
   wire wr_aux;
   wire wr_irq;
   wire q1_tick;
   wire mismatch;
   wire mode_off;
   wire mode_pin;
   wire gate_src;
   wire addr_ok;
   reg next_flag;
   reg [31:0] next_rdata;

   assign apb_access = psel & penable & pready;
   assign addr_ok = (paddr == `CMPCTL_ADDR_CTRL) |
      (paddr == `CMPCTL_ADDR_AUX) | (paddr == `CMPCTL_ADDR_IRQ);
   assign wr_ctrl = apb_access & pwrite & (paddr == `CMPCTL_ADDR_CTRL);
   // every write to control counts as a read for the reference latch
   assign rd_ctrl = apb_access & (paddr == `CMPCTL_ADDR_CTRL);
   assign wr_aux = apb_access & pwrite & (paddr == `CMPCTL_ADDR_AUX);
   assign wr_irq = apb_access & pwrite & (paddr == `CMPCTL_ADDR_IRQ);
   assign q1_tick = (quarter == 2'd0);

   assign mode_off = (comparator_mode_field == `CMPCTL_MODE_OFF0) |
      (comparator_mode_field == `CMPCTL_MODE_OFF7);
   assign mode_pin = (comparator_mode_field == `CMPCTL_MODE_PIN1) |
      (comparator_mode_field == `CMPCTL_MODE_PIN3) |
      (comparator_mode_field == `CMPCTL_MODE_SW_PIN);

   // ************************************************************
   // quarter phase counter
   // ************************************************************
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         quarter <= 2'd0;
      end else begin
         quarter <= quarter + 2'd1;
      end
   end

   // ************************************************************
   // polarity-adjusted result; off modes force low
   // ************************************************************
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         comparator_result_bit <= 1'b0;
      end else begin
         comparator_result_bit <= ~mode_off & (analog_raw ^ output_invert);
      end
   end

   cmpctl_mismatch u_mismatch (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .q1_tick(q1_tick),
      .ref_load(rd_ctrl),
      .result_in(comparator_result_bit),
      .mismatch(mismatch)
   );

   // ************************************************************
   // apb slave
   // ************************************************************
   always @* begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         `CMPCTL_ADDR_CTRL: begin
            next_rdata[`CMPCTL_RESULT_BIT] = comparator_result_bit;
            next_rdata[`CMPCTL_INVERT_BIT] = output_invert;
            next_rdata[`CMPCTL_SWITCH_BIT] = input_switch_select;
            next_rdata[`CMPCTL_MODE_MSB:`CMPCTL_MODE_LSB] =
               comparator_mode_field;
         end
         `CMPCTL_ADDR_AUX: begin
            next_rdata[`CMPCTL_GATESRC_BIT] = timer_gate_source_select;
            next_rdata[`CMPCTL_SYNC_BIT] = output_sync_select;
         end
         `CMPCTL_ADDR_IRQ: begin
            next_rdata[`CMPCTL_FLAG_BIT] = comparator_change_flag;
            next_rdata[`CMPCTL_CHG_EN_BIT] = comparator_change_enable;
            next_rdata[`CMPCTL_PERI_EN_BIT] = peripheral_irq_enable;
            next_rdata[`CMPCTL_GLOB_EN_BIT] = global_irq_enable;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // one wait state: pready rises in the second access cycle
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~addr_ok;
         if (psel & penable & ~pready & ~pwrite) begin
            prdata <= next_rdata;
         end
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         comparator_mode_field <= `CMPCTL_MODE_OFF0;
         input_switch_select <= 1'b0;
         output_invert <= 1'b0;
         output_sync_select <= 1'b0;
         timer_gate_source_select <= 1'b1;
         comparator_change_enable <= 1'b0;
         peripheral_irq_enable <= 1'b0;
         global_irq_enable <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            comparator_mode_field <=
               pwdata[`CMPCTL_MODE_MSB:`CMPCTL_MODE_LSB];
            input_switch_select <= pwdata[`CMPCTL_SWITCH_BIT];
            output_invert <= pwdata[`CMPCTL_INVERT_BIT];
         end
         if (wr_aux) begin
            output_sync_select <= pwdata[`CMPCTL_SYNC_BIT];
            timer_gate_source_select <= pwdata[`CMPCTL_GATESRC_BIT];
         end
         if (wr_irq) begin
            comparator_change_enable <= pwdata[`CMPCTL_CHG_EN_BIT];
            peripheral_irq_enable <= pwdata[`CMPCTL_PERI_EN_BIT];
            global_irq_enable <= pwdata[`CMPCTL_GLOB_EN_BIT];
         end
      end
   end

   // ************************************************************
   // change flag: hardware set wins over software clear
   // ************************************************************
   always @* begin
      next_flag = comparator_change_flag;
      if (wr_irq) begin
         next_flag = pwdata[`CMPCTL_FLAG_BIT];
      end
      // a live mismatch re-asserts the flag, so a clear cannot stick
      if (mismatch) begin
         next_flag = 1'b1;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         comparator_change_flag <= 1'b0;
      end else begin
         comparator_change_flag <= next_flag;
      end
   end

   // ************************************************************
   // timer gate with optional sync on falling prescaled clock
   // ************************************************************
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         timer_clk_d <= 1'b0;
         sync_result <= 1'b0;
      end else begin
         timer_clk_d <= timer_clk_prescaled;
         if (timer_clk_d & ~timer_clk_prescaled) begin
            sync_result <= comparator_result_bit;
         end
      end
   end

   assign gate_src = output_sync_select ? sync_result : comparator_result_bit;

   // ************************************************************
   // outputs, all registered
   // ************************************************************
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         comparator_enable <= 1'b0;
         inverting_sel_positive <= 1'b0;
         positive_pin_analog <= 1'b1;
         negative_pin_analog <= 1'b1;
         result_pin_out <= 1'b0;
         result_pin_oe <= 1'b0;
         irq_request <= 1'b0;
         wake_request <= 1'b0;
         vector_after_wake <= 1'b0;
         timer_count_enable <= 1'b0;
      end else begin
         comparator_enable <= ~mode_off;
         inverting_sel_positive <= input_switch_select;
         // pin roles: off modes and switched modes keep both pins analog
         negative_pin_analog <= 1'b1;
         positive_pin_analog <= (comparator_mode_field[2:1] != 2'b01) &
            (comparator_mode_field != 3'b100);
         result_pin_out <= mode_pin & comparator_result_bit;
         result_pin_oe <= mode_pin;
         irq_request <= comparator_change_flag & comparator_change_enable &
            peripheral_irq_enable & global_irq_enable;
         wake_request <= core_sleeping & comparator_change_flag &
            comparator_change_enable & peripheral_irq_enable;
         vector_after_wake <= global_irq_enable;
         timer_count_enable <= timer_on & (~timer_gate_enable |
            (timer_gate_source_select ? ext_gate_pin : gate_src));
      end
   end

endmodule // cmpctl_top

/* File: dv/cmpctl_props.sv */
// checker: apb timing, mode decode and enable relations of the comparator block
`include "cmpctl_map.vh"

module cmpctl_props (
   // clock and reset
   input logic clk_sys,
   input logic rst_b,
   // apb
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   // core and timer
   input logic core_sleeping,
   input logic timer_on,
   // outputs
   input logic comparator_enable,
   input logic inverting_sel_positive,
   input logic positive_pin_analog,
   input logic negative_pin_analog,
   input logic result_pin_oe,
   input logic irq_request,
   input logic wake_request,
   input logic vector_after_wake,
   input logic timer_count_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] mode_q;
   logic sw_q;
   // age gives registered outputs time to follow a control write
   logic [1:0] age;
   wire ctrl_wr = psel && penable && pready && pwrite
      && paddr == `CMPCTL_ADDR_CTRL;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= 3'h0;
         sw_q <= 1'b0;
         age <= 2'h3;
      end else if (ctrl_wr) begin
         mode_q <= pwdata[2:0];
         sw_q <= pwdata[3];
         age <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   chk_ready_wait: assert property (psel && !penable |-> ##[1:3] (pready && penable))
      else $error("pready late");
   chk_ready_phase: assert property (pready |-> (psel && penable) ##1 !pready)
      else $error("pready outside access");
   chk_err_pair: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0000_0000))
      else $error("bad error response");
   chk_mode_off: assert property (age == 2'h3 && (mode_q == 3'h0 || mode_q == 3'h7) |-> !comparator_enable)
      else $error("comparator on in off mode");
   chk_pin_drive: assert property (age == 2'h3 |-> result_pin_oe == (mode_q == 3'h1 || mode_q == 3'h3 || mode_q == 3'h5))
      else $error("pin drive wrong for mode");
   chk_both_analog: assert property (age == 2'h3 && (mode_q == 3'h5 || mode_q == 3'h6) |-> positive_pin_analog && negative_pin_analog)
      else $error("switched pins not analog");
   chk_switch_sel: assert property (age == 2'h3 |-> inverting_sel_positive == sw_q)
      else $error("input switch wrong");
   chk_irq_global: assert property (irq_request |-> vector_after_wake || $past(vector_after_wake))
      else $error("irq without global enable");
   chk_wake_sleep: assert property (wake_request |-> core_sleeping || $past(core_sleeping) || $past(core_sleeping, 2))
      else $error("wake while awake");
   chk_timer_off: assert property (!timer_on && !$past(timer_on) |-> !timer_count_enable)
      else $error("timer counts while off");
endmodule // cmpctl_props

bind cmpctl_top cmpctl_props u_props (.clk_sys(clk_sys), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .core_sleeping(core_sleeping), .timer_on(timer_on),
   .comparator_enable(comparator_enable),
   .inverting_sel_positive(inverting_sel_positive),
   .positive_pin_analog(positive_pin_analog),
   .negative_pin_analog(negative_pin_analog),
   .result_pin_oe(result_pin_oe), .irq_request(irq_request),
   .wake_request(wake_request), .vector_after_wake(vector_after_wake),
   .timer_count_enable(timer_count_enable));

/* File: dv/cmpctl_analog_model.sv */
// partner: analog comparator output with bias settling, free timer clock
module cmpctl_analog_model (
   // clock and reset
   input logic clk_sys,
   input logic rst_b,
   // from block and bench
   input logic comparator_enable,
   input logic vin_level,
   // to block
   output logic analog_raw,
   output logic timer_clk_prescaled
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] settle;
   logic [2:0] div;
   logic was_on;

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         settle <= 4'h0;
         div <= 3'h0;
         was_on <= 1'b0;
         analog_raw <= 1'b0;
      end else begin
         was_on <= comparator_enable;
         div <= div + 3'h1;
         if (comparator_enable && !was_on) begin
            settle <= 4'hA;
         end else if (settle != 4'h0) begin
            settle <= settle - 4'h1;
         end
         // output is garbage while bias settles or when off
         analog_raw <= (settle != 4'h0 || !comparator_enable) ?
            !analog_raw : vin_level;
      end
   end
   assign timer_clk_prescaled = div[2];
endmodule // cmpctl_analog_model

/* File: dv/test_comparator_control_and_change_detect.sv */
// self-checking bench for the comparator control and change detect block
`include "cmpctl_map.vh"

module test_comparator_control_and_change_detect;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, analog_raw, tclk, err;
   logic sleeping = 1'b0, timer_on = 1'b0, gate_en = 1'b0, ext_gate = 1'b0;
   logic vin_level = 1'b0;
   logic comp_en, sel_pos, pos_an, neg_an, pin_out, pin_oe;
   logic irq, wake, vec, tce;
   int err_count = 0;
   int samples_checked = 0;

   always #50 clk_sys = ~clk_sys;

   cmpctl_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .analog_raw(analog_raw), .core_sleeping(sleeping),
      .timer_clk_prescaled(tclk), .timer_on(timer_on),
      .timer_gate_enable(gate_en), .ext_gate_pin(ext_gate),
      .comparator_enable(comp_en), .inverting_sel_positive(sel_pos),
      .positive_pin_analog(pos_an), .negative_pin_analog(neg_an),
      .result_pin_out(pin_out), .result_pin_oe(pin_oe),
      .irq_request(irq), .wake_request(wake), .vector_after_wake(vec),
      .timer_count_enable(tce));

   cmpctl_analog_model u_model (.clk_sys(clk_sys), .rst_b(rst_b),
      .comparator_enable(comp_en), .vin_level(vin_level),
      .analog_raw(analog_raw), .timer_clk_prescaled(tclk));

   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // apb transfer; slave latency is not assumed, only bounded
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         summarize();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task t_reset;
      apb(0, `CMPCTL_ADDR_CTRL, 0);
      chk("ctrl_reset", rd, 32'h0000_0000);
      apb(0, `CMPCTL_ADDR_AUX, 0);
      chk("aux_reset", rd, 32'h0000_0002);
      apb(0, `CMPCTL_ADDR_IRQ, 0);
      chk("irq_reset", rd, 32'h0000_0000);
      chk("en_reset", comp_en, 0);
      chk("pos_an_reset", pos_an, 1);
      apb(0, 12'h00C, 0);
      chk("unmapped_err", err, 1);
      chk("unmapped_data", rd, 32'h0000_0000);
   endtask

   task t_modes;
      for (int m = 0; m < 8; m++) begin
         apb(1, `CMPCTL_ADDR_CTRL, {28'h000_0000, m[0], m[2:0]});
         cyc(3);
         chk("enable", comp_en, !(m == 0 || m == 7));
         chk("pin_oe", pin_oe, m == 1 || m == 3 || m == 5);
         chk("sel_pos", sel_pos, m[0]);
         chk("pos_analog", pos_an, !(m >= 2 && m <= 4));
         chk("neg_analog", neg_an, 1);
      end
   endtask

   task t_polarity;
      for (int i = 0; i < 4; i++) begin
         vin_level <= i[0];
         apb(1, `CMPCTL_ADDR_CTRL, {27'h000_0000, i[1], 4'h1});
         cyc(14);
         apb(0, `CMPCTL_ADDR_CTRL, 0);
         chk("result_bit", rd[6], i[0] ^ i[1]);
         chk("result_pin", pin_out, i[0] ^ i[1]);
      end
   endtask

   task t_change;
      apb(1, `CMPCTL_ADDR_CTRL, 32'h0000_0002);
      vin_level <= 1'b0;
      cyc(14);
      apb(0, `CMPCTL_ADDR_CTRL, 0);
      apb(1, `CMPCTL_ADDR_IRQ, 0);
      vin_level <= 1'b1;
      cyc(10);
      apb(0, `CMPCTL_ADDR_IRQ, 0);
      chk("flag_set", rd[0], 1);
      apb(1, `CMPCTL_ADDR_IRQ, 0);
      apb(0, `CMPCTL_ADDR_IRQ, 0);
      chk("flag_held", rd[0], 1);
      apb(0, `CMPCTL_ADDR_CTRL, 0);
      apb(1, `CMPCTL_ADDR_IRQ, 0);
      apb(0, `CMPCTL_ADDR_IRQ, 0);
      chk("flag_clear", rd[0], 0);
      vin_level <= 1'b0;
      cyc(10);
      apb(1, `CMPCTL_ADDR_CTRL, 32'h0000_0002);
      apb(1, `CMPCTL_ADDR_IRQ, 0);
      apb(0, `CMPCTL_ADDR_IRQ, 0);
      chk("write_ends", rd[0], 0);
      apb(1, `CMPCTL_ADDR_IRQ, 32'h0000_0001);
      apb(0, `CMPCTL_ADDR_IRQ, 0);
      chk("flag_soft", rd[0], 1);
   endtask

   task t_irq;
      sleeping <= 1'b1;
      apb(1, `CMPCTL_ADDR_IRQ, 32'h0000_0006);
      cyc(3);
      chk("wake_idle", wake, 0);
      vin_level <= 1'b1;
      cyc(12);
      chk("wake_change", wake, 1);
      apb(0, `CMPCTL_ADDR_CTRL, 0);
      apb(1, `CMPCTL_ADDR_IRQ, 32'h0000_0007);
      cyc(3);
      chk("irq_no_glob", irq, 0);
      chk("wake", wake, 1);
      chk("vec_off", vec, 0);
      apb(1, `CMPCTL_ADDR_IRQ, 32'h0000_000F);
      cyc(3);
      chk("irq_all", irq, 1);
      chk("vec_on", vec, 1);
      sleeping <= 1'b0;
      apb(1, `CMPCTL_ADDR_IRQ, 32'h0000_000E);
      cyc(3);
      chk("irq_clear", irq, 0);
      apb(1, `CMPCTL_ADDR_IRQ, 0);
   endtask

   task t_gate;
      timer_on <= 1'b1;
      gate_en <= 1'b1;
      apb(1, `CMPCTL_ADDR_AUX, 0);
      for (int i = 0; i < 2; i++) begin
         vin_level <= !i[0];
         cyc(10);
         chk("gate_cmp", tce, !i[0]);
      end
      apb(1, `CMPCTL_ADDR_AUX, 32'h0000_0001);
      vin_level <= 1'b1;
      cyc(24);
      chk("gate_sync", tce, 1);
      apb(1, `CMPCTL_ADDR_AUX, 32'h0000_0002);
      ext_gate <= 1'b1;
      vin_level <= 1'b0;
      cyc(4);
      chk("gate_pin", tce, 1);
      timer_on <= 1'b0;
      cyc(4);
      chk("timer_off", tce, 0);
   endtask

   initial begin
      cyc(8);
      rst_b <= 1'b1;
      t_reset();
      t_modes();
      t_polarity();
      t_change();
      t_irq();
      t_gate();
      summarize();
   end
endmodule // test_comparator_control_and_change_detect
